// >>> logic/pm_pkg.sv
// constants, register map and types of the per-second error monitor
// assumes a 25 MHz card clock and framers that give one-cycle event pulses
// Behaviour
// [RULE1] path parity counter adds each parity error, at most eight per frame
// [RULE2] path errored second: any parity error or path/lower-layer defect
// [RULE3] failure count adds one per event, which lasts until failures clear
// [RULE4] enhanced remote defect also starts a failure event when supported
// [RULE5] path severe second: 2400 or more parity errors in the second
// [RULE6] path defect in a second makes it severe regardless of errors
// [RULE7] path unavailable after ten severe seconds, back after ten clean
// [RULE8] far-end violation per M-frame whose three error bits are not all 1
// [RULE9] far-end errored second: any bad M-frame or far-end defect
// [RULE10] far-end defect second: any far-end frame or alarm defect
// [RULE11] far-end severe second: 44 or more bad M-frames or a defect
// [RULE12] ten far-end severe seconds make it unavailable, counted backwards
// [RULE13] ten clean seconds restore availability, removed from the count
// [RULE14] line violation counter adds every bipolar and zeros event
// [RULE15] line errored second: any line anomaly or loss of signal
// [RULE16] line severe second: 44 or more anomalies or a line defect
// [RULE17] loss-of-signal second: any loss of signal in the second
// [RULE18] one common second tick from the card clock clears all tallies
// [RULE19] path and far-end errored and severe seconds frozen while that side is unavailable
package pm_pkg;

    // timebase
    localparam int     CLK_PERIOD_NS = 40;
    localparam longint SECOND_NS     = 1000000000;
    localparam int     SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

    // thresholds
    localparam logic [3:0]  FRAME_BIP_MAX   = 4'h8;
    localparam logic [11:0] PATH_SES_ERRORS = 12'h960;
    localparam logic [5:0]  FE_SES_FRAMES   = 6'h2c;
    localparam logic [5:0]  LINE_SES_ERRORS = 6'h2c;
    localparam logic [3:0]  AVAIL_RUN       = 4'ha;
    localparam logic [2:0]  FEBE_CLEAN      = 3'h7;

    // register byte offsets
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] MASK_ADDR   = 8'h08;
    localparam logic [7:0] STATE_ADDR  = 8'h0c;
    localparam logic [7:0] CNT_ADDR    = 8'h10;

    // control and state fields
    localparam int CTRL_ERDI   = 0;
    localparam int CTRL_CLEAR  = 1;
    localparam int ST_P_UNAV   = 0;
    localparam int ST_FE_UNAV  = 1;
    localparam int ST_FAIL     = 2;

    // interrupt events
    localparam int NUM_EV     = 4;
    localparam int EV_TICK    = 0;
    localparam int EV_P_AV    = 1;
    localparam int EV_FE_AV   = 2;
    localparam int EV_FAIL    = 3;
    localparam logic [3:0] MASK_RESET = 4'h0;

    // counter indices, word n at CNT_ADDR + 4n
    localparam int NUM_CNT  = 14;
    localparam int P_CV     = 0;
    localparam int P_ES     = 1;
    localparam int P_FC     = 2;
    localparam int P_SES    = 3;
    localparam int P_UAS    = 4;
    localparam int FE_CV    = 5;
    localparam int FE_ES    = 6;
    localparam int FE_SAS   = 7;
    localparam int FE_SES   = 8;
    localparam int FE_UAS   = 9;
    localparam int L_CV     = 10;
    localparam int L_ES     = 11;
    localparam int L_SES    = 12;
    localparam int L_LOSS   = 13;

    typedef enum logic {AVAILABLE, UNAVAILABLE} avail_state_t;

    typedef struct packed {
        avail_state_t state;
        logic [3:0]   run;
        logic [31:0]  uas;
    } avail_t;

endpackage

// >>> logic/path_line_error_second_monitor.sv
// per-second path, far-end and line error monitor with wishbone registers
// assumes framer event pulses and defect levels synchronous to clk_i
`timescale 1ns/1ps

module path_line_error_second_monitor #(
    parameter int SECOND_CYCLES = pm_pkg::SECOND_CYCLES
) (
    // clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // sts path events
    input  wire logic        path_frame_i,
    input  wire logic [3:0]  path_bip_errors_i,
    input  wire logic        path_ais_i,
    input  wire logic        path_lop_i,
    input  wire logic        lower_defect_i,
    // sts path failures
    input  wire logic        path_ais_fail_i,
    input  wire logic        path_lop_fail_i,
    input  wire logic        path_uneq_fail_i,
    input  wire logic        path_tim_fail_i,
    input  wire logic        enhanced_remote_defect_indication_i,
    // ds3 far-end events
    input  wire logic        m_frame_i,
    input  wire logic [2:0]  febe_bits_i,
    input  wire logic        fe_sef_ais_i,
    // ds3 line events
    input  wire logic        bpv_i,
    input  wire logic        exz_i,
    input  wire logic        los_i,
    // status
    output logic             irq_o,
    output logic             path_unavailable_o,
    output logic             far_end_unavailable_o,
    output logic             failure_active_o
);

    typedef struct packed {
        logic [31:0]                     presc;
        logic [11:0]                     bip_sec;
        logic                            p_def;
        logic [5:0]                      fe_sec;
        logic                            fe_def;
        logic [5:0]                      ln_sec;
        logic                            ln_los;
        pm_pkg::avail_state_t            p_state;
        logic [3:0]                      p_run;
        pm_pkg::avail_state_t            fe_state;
        logic [3:0]                      fe_run;
        logic                            fail_act;
        logic                            erdi_en;
        logic [pm_pkg::NUM_EV-1:0]       status;
        logic [pm_pkg::NUM_EV-1:0]       mask;
        logic                            irq;
        logic                            ack;
        logic [31:0]                     dat;
        logic [pm_pkg::NUM_CNT-1:0][31:0] cnt;
    } state_t;

    state_t                    q;
    state_t                    n;
    logic                      tick;
    logic [3:0]                bip_add;
    logic                      fe_bad;
    logic [1:0]                ln_add;
    logic                      fail_now;
    logic                      p_es;
    logic                      p_ses;
    logic                      fe_es;
    logic                      fe_ses;
    logic                      wr;
    logic                      wr_clear;
    logic [pm_pkg::NUM_EV-1:0] ev;
    logic [pm_pkg::NUM_EV-1:0] w1c;
    logic [31:0]               rd;
    logic [5:0]                cidx;
    pm_pkg::avail_t            pa;
    pm_pkg::avail_t            fa;

    // add with a ceiling; tallies stop at their threshold, never wrap
    function automatic logic [31:0] sat_add(input logic [31:0] v,
                                            input logic [31:0] inc,
                                            input logic [31:0] cap);
        logic [31:0] s;
        s = v + inc;
        return (s > cap) ? cap : s;
    endfunction

    // one second of the availability machine, with retroactive accounting
    function automatic pm_pkg::avail_t avail_step(
        input pm_pkg::avail_state_t st,
        input logic [3:0]           run,
        input logic                 ses,
        input logic [31:0]          uas);
        pm_pkg::avail_t r;
        r.state = st;
        r.run   = 4'h0;
        r.uas   = uas;
        case (st)
            pm_pkg::AVAILABLE: begin
                if (ses && run == pm_pkg::AVAIL_RUN - 4'h1) begin
                    // the ten severe seconds join unavailable time
                    r.state = pm_pkg::UNAVAILABLE;
                    r.uas   = uas + 32'(pm_pkg::AVAIL_RUN);
                end else if (ses) begin
                    r.run = run + 4'h1;
                end
            end
            pm_pkg::UNAVAILABLE: begin
                r.uas = uas + 32'h1;
                if (!ses && run == pm_pkg::AVAIL_RUN - 4'h1) begin
                    // the ten clean seconds leave unavailable time
                    r.state = pm_pkg::AVAILABLE;
                    r.uas   = (r.uas >= 32'(pm_pkg::AVAIL_RUN)) ?
                              r.uas - 32'(pm_pkg::AVAIL_RUN) : 32'h0;
                end else if (!ses) begin
                    r.run = run + 4'h1;
                end
            end
            default: r.state = pm_pkg::AVAILABLE;
        endcase
        return r;
    endfunction

    // register read mux; unmapped words read as zero
    always_comb begin
        rd   = 32'h0;
        cidx = 6'(wb_adr_i[7:2] - pm_pkg::CNT_ADDR[7:2]);
        case (wb_adr_i)
            pm_pkg::CTRL_ADDR:   rd[pm_pkg::CTRL_ERDI] = q.erdi_en;
            pm_pkg::STATUS_ADDR: rd[pm_pkg::NUM_EV-1:0] = q.status;
            pm_pkg::MASK_ADDR:   rd[pm_pkg::NUM_EV-1:0] = q.mask;
            pm_pkg::STATE_ADDR: begin
                rd[pm_pkg::ST_P_UNAV]  = q.p_state;
                rd[pm_pkg::ST_FE_UNAV] = q.fe_state;
                rd[pm_pkg::ST_FAIL]    = q.fail_act;
            end
            default: begin
                if (wb_adr_i >= pm_pkg::CNT_ADDR &&
                    cidx < 6'(pm_pkg::NUM_CNT)) begin
                    rd = q.cnt[cidx];
                end
            end
        endcase
    end

    // next-state logic for the whole block
    always_comb begin
        n  = q;
        ev = '0;

        // [RULE18] one second tick
        tick    = (q.presc == 32'(SECOND_CYCLES - 1));
        n.presc = tick ? 32'h0 : q.presc + 32'h1;

        // [RULE1] cap per-frame errors
        bip_add = 4'h0;
        if (path_frame_i) begin
            bip_add = (path_bip_errors_i > pm_pkg::FRAME_BIP_MAX) ?
                      pm_pkg::FRAME_BIP_MAX : path_bip_errors_i;
        end
        n.cnt[pm_pkg::P_CV] = q.cnt[pm_pkg::P_CV] + 32'(bip_add);
        n.bip_sec = 12'(sat_add(32'(q.bip_sec), 32'(bip_add),
                                32'(pm_pkg::PATH_SES_ERRORS)));
        n.p_def   = q.p_def | path_ais_i | path_lop_i | lower_defect_i;

        // [RULE8] m-frame with an error bit
        fe_bad = m_frame_i && (febe_bits_i != pm_pkg::FEBE_CLEAN);
        n.cnt[pm_pkg::FE_CV] = q.cnt[pm_pkg::FE_CV] + 32'(fe_bad);
        n.fe_sec = 6'(sat_add(32'(q.fe_sec), 32'(fe_bad),
                              32'(pm_pkg::FE_SES_FRAMES)));
        n.fe_def = q.fe_def | fe_sef_ais_i;

        // [RULE14] both anomalies count
        ln_add = {1'b0, bpv_i} + {1'b0, exz_i};
        n.cnt[pm_pkg::L_CV] = q.cnt[pm_pkg::L_CV] + 32'(ln_add);
        n.ln_sec = 6'(sat_add(32'(q.ln_sec), 32'(ln_add),
                              32'(pm_pkg::LINE_SES_ERRORS)));
        n.ln_los = q.ln_los | los_i;

        // [RULE3] event opens on the first failure, closes when all clear
        // [RULE4] enhanced remote defect only when enabled
        fail_now = path_ais_fail_i | path_lop_fail_i | path_uneq_fail_i |
                   path_tim_fail_i |
                   (q.erdi_en & enhanced_remote_defect_indication_i);
        n.fail_act = fail_now;
        if (fail_now && !q.fail_act) begin
            n.cnt[pm_pkg::P_FC] = q.cnt[pm_pkg::P_FC] + 32'h1;
            ev[pm_pkg::EV_FAIL] = 1'b1;
        end

        // [RULE2] [RULE6] qualify the closing second, this cycle included
        // [RULE5] parity threshold
        p_es  = (n.bip_sec != 12'h0) || n.p_def;
        p_ses = (n.bip_sec >= pm_pkg::PATH_SES_ERRORS) || n.p_def;
        // [RULE9] [RULE11] far-end qualification
        fe_es  = (n.fe_sec != 6'h0) || n.fe_def;
        fe_ses = (n.fe_sec >= pm_pkg::FE_SES_FRAMES) || n.fe_def;
        pa = avail_step(q.p_state, q.p_run, p_ses, q.cnt[pm_pkg::P_UAS]);
        fa = avail_step(q.fe_state, q.fe_run, fe_ses,
                        q.cnt[pm_pkg::FE_UAS]);

        if (tick) begin
            ev[pm_pkg::EV_TICK] = 1'b1;
            // [RULE19] frozen while unavailable
            if (q.p_state == pm_pkg::AVAILABLE) begin
                n.cnt[pm_pkg::P_ES]  = q.cnt[pm_pkg::P_ES] + 32'(p_es);
                n.cnt[pm_pkg::P_SES] = q.cnt[pm_pkg::P_SES] + 32'(p_ses);
            end
            if (q.fe_state == pm_pkg::AVAILABLE) begin
                n.cnt[pm_pkg::FE_ES]  = q.cnt[pm_pkg::FE_ES] + 32'(fe_es);
                n.cnt[pm_pkg::FE_SES] = q.cnt[pm_pkg::FE_SES] +
                                        32'(fe_ses);
            end
            // [RULE10] defect seconds
            n.cnt[pm_pkg::FE_SAS] = q.cnt[pm_pkg::FE_SAS] + 32'(n.fe_def);

            // [RULE7] path availability
            n.p_state            = pa.state;
            n.p_run              = pa.run;
            n.cnt[pm_pkg::P_UAS] = pa.uas;
            ev[pm_pkg::EV_P_AV]  = (pa.state != q.p_state);
            // [RULE12] [RULE13] far-end availability
            n.fe_state            = fa.state;
            n.fe_run              = fa.run;
            n.cnt[pm_pkg::FE_UAS] = fa.uas;
            ev[pm_pkg::EV_FE_AV]  = (fa.state != q.fe_state);

            // [RULE15] [RULE16] [RULE17] line seconds
            n.cnt[pm_pkg::L_ES] = q.cnt[pm_pkg::L_ES] +
                32'((n.ln_sec != 6'h0) || n.ln_los);
            n.cnt[pm_pkg::L_SES] = q.cnt[pm_pkg::L_SES] +
                32'((n.ln_sec >= pm_pkg::LINE_SES_ERRORS) || n.ln_los);
            n.cnt[pm_pkg::L_LOSS] = q.cnt[pm_pkg::L_LOSS] + 32'(n.ln_los);

            // [RULE18] tallies restart
            n.bip_sec = 12'h0;
            n.p_def   = 1'b0;
            n.fe_sec  = 6'h0;
            n.fe_def  = 1'b0;
            n.ln_sec  = 6'h0;
            n.ln_los  = 1'b0;
        end

        // bus: ack one cycle after the request, write at the ack edge
        n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        if (!q.ack) begin
            n.dat = rd;
        end
        wr       = wb_cyc_i & wb_stb_i & wb_we_i & q.ack & wb_sel_i[0];
        wr_clear = 1'b0;
        w1c      = '0;
        if (wr && wb_adr_i == pm_pkg::CTRL_ADDR) begin
            n.erdi_en = wb_dat_i[pm_pkg::CTRL_ERDI];
            wr_clear  = wb_dat_i[pm_pkg::CTRL_CLEAR];
        end
        if (wr && wb_adr_i == pm_pkg::MASK_ADDR) begin
            n.mask = wb_dat_i[pm_pkg::NUM_EV-1:0];
        end
        if (wr && wb_adr_i == pm_pkg::STATUS_ADDR) begin
            w1c = wb_dat_i[pm_pkg::NUM_EV-1:0];
        end

        // a new event wins over a clear in the same cycle
        n.status = (q.status & ~w1c) | ev;
        n.irq    = |(n.status & n.mask);

        // clearing wins over counting; availability state is kept
        if (wr_clear) begin
            n.cnt = '0;
        end
    end

    // single state register; ce_i low freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.mask <= pm_pkg::MASK_RESET;
        end else if (ce_i) begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign wb_dat_o              = q.dat;
    assign wb_ack_o              = q.ack;
    assign irq_o                 = q.irq;
    assign path_unavailable_o    = q.p_state;
    assign far_end_unavailable_o = q.fe_state;
    assign failure_active_o      = q.fail_act;

    // checks on the block's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_tick;
        ce_i && tick && !wr_clear;
    endsequence

    sequence s_fe_tenth_ses;
        s_tick ##0 (q.fe_state == pm_pkg::AVAILABLE) && fe_ses &&
        (q.fe_run == pm_pkg::AVAIL_RUN - 4'h1);
    endsequence

    sequence s_fe_tenth_clean;
        s_tick ##0 (q.fe_state == pm_pkg::UNAVAILABLE) && !fe_ses &&
        (q.fe_run == pm_pkg::AVAIL_RUN - 4'h1);
    endsequence

    bus_ack_pulse_a: assert property (ce_i && q.ack |=> !q.ack)
        else $error("ack held longer than one cycle");

    frame_bip_cap_a: assert property ( // [RULE1]
        ce_i && path_frame_i && !wr_clear &&
        path_bip_errors_i > pm_pkg::FRAME_BIP_MAX |=>
        q.cnt[pm_pkg::P_CV] == $past(q.cnt[pm_pkg::P_CV]) + 32'h8)
        else $error("parity count not capped at eight");

    path_es_count_a: assert property ( // [RULE2]
        s_tick ##0 p_es && q.p_state == pm_pkg::AVAILABLE |=>
        q.cnt[pm_pkg::P_ES] == $past(q.cnt[pm_pkg::P_ES]) + 32'h1)
        else $error("path errored second missed");

    fail_start_a: assert property ( // [RULE3]
        ce_i && fail_now && !q.fail_act && !wr_clear |=>
        q.cnt[pm_pkg::P_FC] == $past(q.cnt[pm_pkg::P_FC]) + 32'h1 &&
        q.fail_act)
        else $error("failure event not counted");

    erdi_gate_a: assert property ( // [RULE4]
        ce_i && !q.erdi_en && !path_ais_fail_i && !path_lop_fail_i &&
        !path_uneq_fail_i && !path_tim_fail_i |=> !q.fail_act)
        else $error("disabled remote defect opened an event");

    path_ses_count_a: assert property ( // [RULE5]
        s_tick ##0 n.bip_sec >= pm_pkg::PATH_SES_ERRORS &&
        q.p_state == pm_pkg::AVAILABLE |=>
        q.cnt[pm_pkg::P_SES] == $past(q.cnt[pm_pkg::P_SES]) + 32'h1)
        else $error("path severe second missed");

    defect_severe_a: assert property ( // [RULE6]
        ce_i && tick && (path_ais_i || lower_defect_i) |-> p_ses)
        else $error("defect second not severe");

    path_unav_entry_a: assert property ( // [RULE7]
        s_tick ##0 q.p_state == pm_pkg::AVAILABLE && p_ses &&
        q.p_run == pm_pkg::AVAIL_RUN - 4'h1 |=> path_unavailable_o)
        else $error("path not unavailable after ten");

    fe_cv_count_a: assert property ( // [RULE8]
        ce_i && m_frame_i && febe_bits_i == pm_pkg::FEBE_CLEAN &&
        !wr_clear |=> $stable(q.cnt[pm_pkg::FE_CV]))
        else $error("clean m-frame counted");

    fe_unav_entry_a: assert property ( // [RULE12]
        s_fe_tenth_ses |=> far_end_unavailable_o &&
        q.cnt[pm_pkg::FE_UAS] == $past(q.cnt[pm_pkg::FE_UAS]) + 32'ha)
        else $error("far-end entry not retroactive");

    fe_unav_exit_a: assert property ( // [RULE13]
        s_fe_tenth_clean ##0 q.cnt[pm_pkg::FE_UAS] >= 32'h9 |=>
        !far_end_unavailable_o &&
        q.cnt[pm_pkg::FE_UAS] == $past(q.cnt[pm_pkg::FE_UAS]) - 32'h9)
        else $error("far-end exit not removed");

    line_cv_both_a: assert property ( // [RULE14]
        ce_i && bpv_i && exz_i && !wr_clear |=>
        q.cnt[pm_pkg::L_CV] == $past(q.cnt[pm_pkg::L_CV]) + 32'h2)
        else $error("line anomalies not both counted");

    tally_clear_a: assert property ( // [RULE18]
        ce_i && tick |=> q.bip_sec == 12'h0 && q.fe_sec == 6'h0 &&
        q.ln_sec == 6'h0 && !q.ln_los && !q.p_def && !q.fe_def)
        else $error("tally not cleared at tick");

    unav_frozen_a: assert property ( // [RULE19]
        s_tick ##0 q.p_state == pm_pkg::UNAVAILABLE |=>
        $stable(q.cnt[pm_pkg::P_ES]) && $stable(q.cnt[pm_pkg::P_SES]))
        else $error("errored seconds counted while unavailable");

    irq_level_a: assert property (
        irq_o == |(q.status & q.mask))
        else $error("interrupt level wrong");

endmodule // path_line_error_second_monitor

// >>> verif/framer_model.sv
// framer and overhead extraction model feeding the monitor's event inputs
// assumes the bench calls each task from one process at a time
`timescale 1ns/1ps

module framer_model (
    // clock
    input  wire logic       clk_i,
    // sts path side
    output logic            frame_o,
    output logic [3:0]      bip_o,
    output logic [2:0]      defect_o,
    output logic [4:0]      fail_o,
    // ds3 side
    output logic            mframe_o,
    output logic [2:0]      febe_o,
    output logic            fe_def_o,
    output logic            bpv_o,
    output logic            exz_o,
    output logic            los_o
);
    // quiet lines at time zero
    initial begin
        {frame_o, bip_o, defect_o, fail_o, mframe_o} = '0;
        {febe_o, fe_def_o, bpv_o, exz_o, los_o} = '0;
    end

    // between frames the error fields carry junk, the inverse of the last count
    task automatic frames(input int n, input logic [3:0] b);
        repeat (n) begin
            @(posedge clk_i);
            {frame_o, bip_o} <= {1'b1, b};
        end
        @(posedge clk_i);
        {frame_o, bip_o} <= {1'b0, ~b};
    endtask

    // m-frames, far-end bits inverted once the frame pulse is gone
    task automatic mframes(input int n, input logic [2:0] f);
        repeat (n) begin
            @(posedge clk_i);
            {mframe_o, febe_o} <= {1'b1, f};
        end
        @(posedge clk_i);
        {mframe_o, febe_o} <= {1'b0, ~f};
    endtask

    // line anomaly pulses, one of each kind per cycle at most
    task automatic line(input int n, input logic bv, input logic ez);
        repeat (n) begin
            @(posedge clk_i);
            {bpv_o, exz_o} <= {bv, ez};
        end
        @(posedge clk_i);
        {bpv_o, exz_o} <= 2'b00;
    endtask

    // defect and failure levels: ais, lop, lower / ais, lop, uneq, tim, erdi
    task automatic levels(input logic [2:0] d, input logic fe, input logic l);
        @(posedge clk_i);
        {defect_o, fe_def_o, los_o} <= {d, fe, l};
    endtask

    task automatic fails(input logic [4:0] f);
        @(posedge clk_i);
        fail_o <= f;
    endtask
endmodule // framer_model

// >>> verif/tb_top.sv
// self-checking bench for the per-second error monitor
// assumes a second shortened to SC clocks and the framer model
`timescale 1ns/1ps

module tb_top;
    localparam int SC = 500;
    logic        clk, rst, ce, cyc, stb, we, ack, irq, p_unav, fe_unav;
    logic        fail_act, frame, mframe, fe_def, bpv, exz, los;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0]  bip, sel;
    logic [2:0]  dfct, febe;
    logic [4:0]  fail;
    logic [31:0] exp_c [14] = '{default: '0};
    int          bad_count, check_count;

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    path_line_error_second_monitor #(.SECOND_CYCLES(SC)) u_dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .path_frame_i(frame), .path_bip_errors_i(bip),
        .path_ais_i(dfct[2]), .path_lop_i(dfct[1]), .lower_defect_i(dfct[0]),
        .path_ais_fail_i(fail[4]), .path_lop_fail_i(fail[3]),
        .path_uneq_fail_i(fail[2]), .path_tim_fail_i(fail[1]),
        .enhanced_remote_defect_indication_i(fail[0]),
        .m_frame_i(mframe), .febe_bits_i(febe), .fe_sef_ais_i(fe_def),
        .bpv_i(bpv), .exz_i(exz), .los_i(los), .irq_o(irq),
        .path_unavailable_o(p_unav), .far_end_unavailable_o(fe_unav),
        .failure_active_o(fail_act));

    framer_model u_framer (
        .clk_i(clk), .frame_o(frame), .bip_o(bip), .defect_o(dfct),
        .fail_o(fail), .mframe_o(mframe), .febe_o(febe), .fe_def_o(fe_def),
        .bpv_o(bpv), .exz_o(exz), .los_o(los));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, e);
        end
    endtask

    // classic cycle: hold until ack is sampled high at a rising edge
    task automatic wb(input logic [7:0] a, logic w, logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            bad_count++;
            complete_run();
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, '0);
        chk_val(q, e);
    endtask

    task automatic chk_all();
        for (int i = 0; i < 14; i++) chk_reg(8'h10 + 8'(4 * i), exp_c[i]);
    endtask

    // irq is registered, so let it settle before looking
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        chk_val({31'h0, irq}, {31'h0, e});
    endtask

    // bit i of m selects counter word i
    task automatic add(input logic [13:0] m, input int v);
        for (int i = 0; i < 14; i++) if (m[i]) exp_c[i] += 32'(v);
    endtask

    // the second tick is the only unmasked status bit while waiting
    task automatic wait_tick();
        int n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (irq !== 1'b1 && n < 2 * SC);
        if (irq !== 1'b1) begin
            bad_count++;
            complete_run();
        end
        wb(pm_pkg::STATUS_ADDR, 1'b1, 32'h1);
        repeat (2) @(posedge clk);
    endtask

    initial begin
        {rst, ce, sel} = '1;
        {cyc, stb, we, adr, wdat, q} = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) chk_reg(8'(4 * i), '0);
        chk_reg(8'h80, '0);
        wb(8'h10, 1'b1, 32'hff);
        chk_all();
        $display("test reset done");
        wb(pm_pkg::MASK_ADDR, 1'b1, 32'h1);
        wait_tick();
        fork
            u_framer.frames(3, 4'ha);
            u_framer.mframes(2, 3'b110);
            u_framer.line(4, 1'b1, 1'b1);
        join
        ce <= 1'b0;
        u_framer.frames(1, 4'h3);
        ce <= 1'b1;
        u_framer.mframes(1, 3'b111);
        u_framer.line(2, 1'b1, 1'b0);
        exp_c[0] += 24;
        exp_c[5] += 2;
        exp_c[10] += 10;
        add(14'h0842, 1);
        wait_tick();
        chk_all();
        wait_tick();
        chk_all();
        u_framer.levels(3'b010, 1'b1, 1'b1);
        u_framer.levels(3'b000, 1'b0, 1'b0);
        add(14'h39ca, 1);
        wait_tick();
        chk_all();
        $display("test seconds done");
        for (int k = 0; k < 2; k++) begin
            fork
                u_framer.frames(299, 4'h8);
                u_framer.mframes(44 - k, 3'b011);
                u_framer.line(22 - k, 1'b1, 1'b1);
            join
            u_framer.line(k, 1'b1, 1'b0);
            u_framer.frames(1, 4'(8 - k));
            exp_c[0] += 32'(2400 - k);
            exp_c[5] += 32'(44 - k);
            exp_c[10] += 32'(44 - k);
            add(14'h0842, 1);
            add(14'h1108, 1 - k);
            wait_tick();
            chk_all();
        end
        $display("test thresholds done");
        u_framer.levels(3'b100, 1'b1, 1'b0);
        for (int i = 0; i < 10; i++) begin
            wait_tick();
            chk_val({31'h0, p_unav}, {31'h0, i == 9});
            chk_val({31'h0, fe_unav}, {31'h0, i == 9});
            u_framer.levels(3'b100 >> (i % 3), 1'b1, 1'b0);
        end
        add(14'h03da, 10);
        chk_reg(pm_pkg::STATUS_ADDR, 32'h6);
        chk_irq(1'b0);
        wb(pm_pkg::MASK_ADDR, 1'b1, 32'h6);
        chk_irq(1'b1);
        wb(pm_pkg::STATUS_ADDR, 1'b1, 32'h6);
        chk_irq(1'b0);
        chk_reg(pm_pkg::STATUS_ADDR, '0);
        wb(pm_pkg::MASK_ADDR, 1'b1, 32'h1);
        chk_reg(pm_pkg::STATE_ADDR, 32'h3);
        chk_all();
        u_framer.levels(3'b000, 1'b0, 1'b0);
        wait_tick();
        add(14'h0290, 1);
        chk_all();
        for (int i = 0; i < 10; i++) wait_tick();
        chk_reg(pm_pkg::STATE_ADDR, '0);
        chk_all();
        $display("test availability done");
        for (int i = 0; i < 4; i++) begin
            u_framer.fails(5'h10 >> i);
            u_framer.fails(5'h10 >> ((i + 1) % 4));
            repeat (2) @(posedge clk);
            chk_val({31'h0, fail_act}, 32'h1);
            u_framer.fails('0);
            repeat (2) @(posedge clk);
            chk_val({31'h0, fail_act}, '0);
        end
        u_framer.fails(5'h01);
        u_framer.fails('0);
        wb(pm_pkg::CTRL_ADDR, 1'b1, 32'h1);
        u_framer.fails(5'h01);
        u_framer.fails('0);
        exp_c[2] += 5;
        sel <= 4'he;
        wb(pm_pkg::CTRL_ADDR, 1'b1, 32'h2);
        sel <= 4'hf;
        chk_reg(pm_pkg::CTRL_ADDR, 32'h1);
        chk_all();
        wb(pm_pkg::CTRL_ADDR, 1'b1, 32'h2);
        foreach (exp_c[i]) exp_c[i] = '0;
        chk_all();
        chk_reg(pm_pkg::CTRL_ADDR, '0);
        $display("test failures done");
        complete_run();
    end
endmodule // tb_top
